// ===== src/iopsc_pkg.sv
// Constants and types for the I/O port structure control block
//
// Function
// - Sixty-four I/O lines as eight 8-bit ports, each bit latch, driver, buffer.
// - Each bidirectional port is read and written through its own port register.
// - Structure-select bit switches all ports between quasi and true bidirectional.
// - Reset selects quasi-bidirectional; CMOS structure only after software sets it.
// - Port zero drives low address, then carries data byte, time multiplexed.
// - Port two drives high address only for 16-bit accesses, else its latch.
// - Analog input ports are input only; reads give levels, writes do nothing.
// - Analog channel comes from three-bit first or four-bit second control field.
// - Analog input ports are byte-read only, all lines sampled together.
// - Direction register shares its port's address; analog ports have none.
// - Setting direction access, then the next instruction accesses direction register.
// - Direction access clears itself at second state-two-phase-two after being set.
// - Interrupts are blocked while the direction access window is open.
// - Direction registers reset to all ones, so pins start as inputs.
// - In quasi-bidirectional structure direction registers never affect drivers.
package iopsc_pkg;
  localparam int PORT_W = 8;
  localparam int NUM_BIDIR = 8;
  localparam int NUM_LINES = 64;
  localparam int SEL_W = 4;
  // Port selector codes; bidirectional ports take codes 0 to 7
  localparam logic [3:0] PORT_ZERO_IDX = 4'h0;
  localparam logic [3:0] PORT_TWO_IDX = 4'h2;
  localparam logic [3:0] ANALOG_A_IDX = 4'h8;
  localparam logic [3:0] ANALOG_B_IDX = 4'h9;
  // Reset values
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic STRUCT_RESET = 1'b0;
  // Phase strobes counted before the direction window closes
  localparam logic [1:0] DIR_WINDOW_STROBES = 2'h2;

  typedef struct packed {
    logic [NUM_BIDIR-1:0][PORT_W-1:0] latch;
    logic [NUM_BIDIR-1:0][PORT_W-1:0] dir;
    logic structSel;
    logic dirAccess;
    logic [1:0] strobeCnt;
    logic [NUM_LINES-1:0] pinMeta;
    logic [NUM_LINES-1:0] pinSync;
    logic [2*PORT_W-1:0] anaMeta;
    logic [2*PORT_W-1:0] anaSync;
    logic [NUM_LINES-1:0] padOut;
    logic [NUM_LINES-1:0] padOe;
    logic [PORT_W-1:0] rdData;
    logic [PORT_W-1:0] extRdData;
    logic [3:0] channel;
  } iopsc_state_type;
endpackage : iopsc_pkg

// ===== src/iopsc_port_ctrl.sv
// Port latches, direction registers, structure select and pin drivers
`timescale 1ns/1ps
module iopsc_port_ctrl (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [3:0] sfrPortSel,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  input wire logic structWrite,
  input wire logic structData,
  output logic portStructureSelect,
  input wire logic dirAccessSet,
  input wire logic stateTwoPhaseTwo,
  output logic directionAccessEnable,
  output logic interruptBlock,
  input wire logic [63:0] padIn,
  output logic [63:0] padOut,
  output logic [63:0] padOe,
  input wire logic [7:0] analogInputPortA,
  input wire logic [7:0] analogInputPortB,
  input wire logic [2:0] convCtrlFirstChan,
  input wire logic [3:0] convCtrlSecondChan,
  input wire logic useSecondChan,
  output logic [3:0] analogChannel,
  input wire logic extAccess,
  input wire logic extAddrPhase,
  input wire logic extWriteCycle,
  input wire logic extWide16,
  input wire logic [15:0] extAddr,
  input wire logic [7:0] extWrData,
  output logic [7:0] extRdData
);
  iopsc_pkg::iopsc_state_type state_reg;
  iopsc_pkg::iopsc_state_type state_next;

  // Bidirectional ports own codes 0 to 7; analog ports have no latch
  function automatic logic isBidir(input logic [3:0] sel);
    isBidir = (sel < 4'(iopsc_pkg::NUM_BIDIR));
  endfunction : isBidir

  // Next state: register access, window timing, driver selection
  always_comb begin
    logic [2:0] idx;
    logic [7:0] drvOut;
    logic [7:0] drvOe;
    state_next = state_reg;
    idx = sfrPortSel[2:0];
    drvOut = 8'h00;
    drvOe = 8'h00;
    // Two flip-flop synchronisers on every pin input
    state_next.pinMeta = padIn;
    state_next.pinSync = state_reg.pinMeta;
    state_next.anaMeta = {analogInputPortB, analogInputPortA};
    state_next.anaSync = state_reg.anaMeta;
    if (structWrite) begin
      state_next.structSel = structData;
    end
    // Window closes on second strobe; a new set wins over the clear
    if (state_reg.dirAccess && stateTwoPhaseTwo) begin
      state_next.strobeCnt = state_reg.strobeCnt + 2'h1;
      if (state_reg.strobeCnt + 2'h1 == iopsc_pkg::DIR_WINDOW_STROBES) begin
        state_next.dirAccess = 1'b0;
      end
    end
    if (dirAccessSet) begin
      state_next.dirAccess = 1'b1;
      state_next.strobeCnt = 2'h0;
    end
    // Writes: direction register only inside the window; analog ignored
    if (sfrWrite && isBidir(sfrPortSel)) begin
      if (state_reg.dirAccess) begin
        state_next.dir[idx] = sfrWrData;
      end else begin
        state_next.latch[idx] = sfrWrData;
      end
    end
    // Reads: pin levels for ports, direction register inside the window, whole byte for analog ports
    if (sfrRead) begin
      if (isBidir(sfrPortSel)) begin
        state_next.rdData = state_reg.dirAccess ? state_reg.dir[idx]
                          : state_reg.pinSync[8*idx +: 8];
      end else if (sfrPortSel == iopsc_pkg::ANALOG_A_IDX) begin
        state_next.rdData = state_reg.anaSync[7:0];
      end else if (sfrPortSel == iopsc_pkg::ANALOG_B_IDX) begin
        state_next.rdData = state_reg.anaSync[15:8];
      end else begin
        state_next.rdData = 8'h00;
      end
    end
    state_next.channel = useSecondChan ? convCtrlSecondChan
                       : {1'b0, convCtrlFirstChan};
    // Per-port drivers; quasi mode pulls low only, pull-up is external
    for (int p = 0; p < iopsc_pkg::NUM_BIDIR; p++) begin
      if (state_reg.structSel) begin
        drvOut = state_reg.latch[p];
        drvOe = ~state_reg.dir[p];
      end else begin
        drvOut = 8'h00;
        drvOe = ~state_reg.latch[p];
      end
      state_next.padOut[8*p +: 8] = drvOut;
      state_next.padOe[8*p +: 8] = drvOe;
    end
    // External bus takes over port zero and, for wide addresses, port two
    if (extAccess) begin
      if (extAddrPhase) begin
        state_next.padOut[7:0] = extAddr[7:0];
        state_next.padOe[7:0] = 8'hFF;
      end else begin
        state_next.padOut[7:0] = extWrData;
        state_next.padOe[7:0] = extWriteCycle ? 8'hFF : 8'h00;
      end
      if (extWide16) begin
        state_next.padOut[23:16] = extAddr[15:8];
        state_next.padOe[23:16] = 8'hFF;
      end
    end
    state_next.extRdData = state_reg.pinSync[7:0];
  end

  // State register; reset gives quasi structure and input directions
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.latch <= {iopsc_pkg::NUM_BIDIR{iopsc_pkg::LATCH_RESET}};
      state_reg.dir <= {iopsc_pkg::NUM_BIDIR{iopsc_pkg::DIR_RESET}};
      state_reg.structSel <= iopsc_pkg::STRUCT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfrRdData = state_reg.rdData;
  assign portStructureSelect = state_reg.structSel;
  assign directionAccessEnable = state_reg.dirAccess;
  // Interrupts held off for the whole direction window
  assign interruptBlock = state_reg.dirAccess;
  assign padOut = state_reg.padOut;
  assign padOe = state_reg.padOe;
  assign analogChannel = state_reg.channel;
  assign extRdData = state_reg.extRdData;
endmodule : iopsc_port_ctrl

// ===== bench/iopsc_props.sv
// Checker watching the port structure control block
`timescale 1ns/1ps
module iopsc_props (
  input wire logic ref_clk, arst_n, dirAccessSet, stateTwoPhaseTwo,
  input wire logic directionAccessEnable, interruptBlock, structWrite,
  input wire logic structData, portStructureSelect, extAccess,
  input wire logic extAddrPhase, extWide16, useSecondChan,
  input wire logic [63:0] padOut, padOe,
  input wire logic [15:0] extAddr,
  input wire logic [2:0] convCtrlFirstChan,
  input wire logic [3:0] convCtrlSecondChan, analogChannel
);
  logic [1:0] cnt;
  logic [3:0] chanExp;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Channel the selector should pick
  assign chanExp = useSecondChan ? convCtrlSecondChan :
    {1'h0, convCtrlFirstChan};
  // Strobes since the last set; a set restarts the count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) cnt <= 2'h0;
    else if (dirAccessSet) cnt <= 2'h0;
    else if (directionAccessEnable && stateTwoPhaseTwo) cnt <= cnt + 2'h1;
  end
  sequence s_strobe;
    directionAccessEnable && stateTwoPhaseTwo && !dirAccessSet;
  endsequence
  property p_open; dirAccessSet |=> directionAccessEnable; endproperty
  a_open: assert property (p_open) else $error("window shut");
  property p_close; s_strobe ##0 cnt == 2'h1 |=> !directionAccessEnable;
  endproperty
  a_close: assert property (p_close) else $error("window stuck");
  property p_irq; interruptBlock == directionAccessEnable; endproperty
  a_irq: assert property (p_irq) else $error("irq block off");
  property p_struct; structWrite |=> portStructureSelect == $past(structData);
  endproperty
  a_struct: assert property (p_struct) else $error("bad structure");
  property p_quasi; !$past(portStructureSelect) |-> padOut[63:24] == 40'h0;
  endproperty
  a_quasi: assert property (p_quasi) else $error("quasi drive");
  property p_addr; extAccess && extAddrPhase |=>
    padOut[7:0] == $past(extAddr[7:0]) && padOe[7:0] == 8'hFF; endproperty
  a_addr: assert property (p_addr) else $error("low address");
  property p_wide; extAccess && extWide16 |=>
    padOut[23:16] == $past(extAddr[15:8]) && padOe[23:16] == 8'hFF;
  endproperty
  a_wide: assert property (p_wide) else $error("high address");
  property p_chan; 1'h1 |=> analogChannel == $past(chanExp); endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
endmodule : iopsc_props
bind iopsc_port_ctrl iopsc_props i_props (.ref_clk, .arst_n, .dirAccessSet,
  .stateTwoPhaseTwo, .directionAccessEnable, .interruptBlock, .structWrite,
  .structData, .portStructureSelect, .extAccess, .extAddrPhase, .extWide16,
  .useSecondChan, .padOut, .padOe, .extAddr, .convCtrlFirstChan,
  .convCtrlSecondChan, .analogChannel);

// ===== bench/iopsc_pins.sv
// Pin model: pull-ups, outside drivers and the device's drivers
`timescale 1ns/1ps
module iopsc_pins (
  input wire logic [63:0] padOut, padOe, extVal, extEn,
  output logic [63:0] padIn
);
  // Undriven lines float to the pull-up, never to a stale value
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      padIn[i] = padOe[i] ? padOut[i] : (extEn[i] ? extVal[i] : 1'h1);
    end
  end
endmodule : iopsc_pins

// ===== bench/io_port_structure_control_test.sv
// Self-checking bench for the port structure control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module io_port_structure_control_test;
  logic ref_clk = 0, arst_n = 0, sfrWrite = 0, sfrRead = 0, structWrite = 0;
  logic structData = 0, dirAccessSet = 0, stateTwoPhaseTwo = 0;
  logic extAccess = 0, extAddrPhase = 0, extWriteCycle = 0, extWide16 = 0;
  logic useSecondChan = 0, portStructureSelect, directionAccessEnable;
  logic interruptBlock;
  logic [3:0] sfrPortSel = 0, convCtrlSecondChan = 0, analogChannel;
  logic [2:0] convCtrlFirstChan = 0;
  logic [7:0] sfrWrData = 0, extWrData = 0, sfrRdData, extRdData;
  logic [7:0] analogInputPortA = 8'h3C, analogInputPortB = 8'hC3;
  logic [15:0] extAddr = 0;
  logic [63:0] padIn, padOut, padOe, extVal = 0, extEn = 0;
  int err_total = 0, n_tests = 0;
  iopsc_port_ctrl i_dut (.ref_clk, .arst_n, .sfrWrite, .sfrRead, .sfrPortSel,
    .sfrWrData, .sfrRdData, .structWrite, .structData, .portStructureSelect,
    .dirAccessSet, .stateTwoPhaseTwo, .directionAccessEnable, .interruptBlock,
    .padIn, .padOut, .padOe, .analogInputPortA, .analogInputPortB,
    .convCtrlFirstChan, .convCtrlSecondChan, .useSecondChan, .analogChannel,
    .extAccess, .extAddrPhase, .extWriteCycle, .extWide16, .extAddr,
    .extWrData, .extRdData);
  iopsc_pins i_pins (.padOut, .padOe, .extVal, .extEn, .padIn);
  // Free-running clock; all inputs change on falling edges
  always #5 ref_clk = ~ref_clk;
  task tick(input int n); repeat (n) @(negedge ref_clk); endtask : tick
  task wr(input logic [3:0] s, input logic [7:0] d);
    sfrPortSel = s; sfrWrData = d; sfrWrite = 1; tick(1); sfrWrite = 0; tick(4);
  endtask : wr
  task rd(input logic [3:0] s, input logic [7:0] e);
    sfrPortSel = s; sfrRead = 1; tick(1); sfrRead = 0;
    `CHK("rd", e, sfrRdData)
    tick(1);
  endtask : rd
  task win; dirAccessSet = 1; tick(1); dirAccessSet = 0; endtask : win
  // Two timing strobes close the direction window
  task shut; repeat (2) begin stateTwoPhaseTwo = 1; tick(1);
    stateTwoPhaseTwo = 0; tick(1); end endtask : shut
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // Main sequence: quasi, analog, bidirectional, window, external bus
  initial begin
    tick(6); arst_n = 1; tick(1);
    `CHK("oe", 64'h0, padOe)
    win; rd(4'h5, 8'hFF); shut;
    wr(4'h3, 8'h5A); `CHK("oe3", 8'hA5, padOe[31:24])
    rd(4'h3, 8'h5A);
    win; wr(4'h3, 8'h00); shut; `CHK("oe3q", 8'hA5, padOe[31:24])
    wr(4'h8, 8'h00); rd(4'h8, 8'h3C); rd(4'h9, 8'hC3);
    `CHK("mask", 8'h03, sfrRdData & 8'h0F)
    convCtrlFirstChan = 3'h5; tick(2); `CHK("ch", 4'h5, analogChannel)
    useSecondChan = 1; convCtrlSecondChan = 4'hB; tick(2);
    `CHK("ch2", 4'hB, analogChannel)
    $display("quasi and analog test done");
    structData = 1; structWrite = 1; tick(1); structWrite = 0; tick(2);
    `CHK("pss", 1'h1, portStructureSelect)
    `CHK("oe5", 8'h00, padOe[47:40])
    `CHK("out5", 8'hFF, padOut[47:40])
    win; wr(4'h3, 8'h0F); shut;
    `CHK("oe3b", 8'hF0, padOe[31:24])
    rd(4'h3, 8'h5F);
    win; `CHK("irq", 1'h1, interruptBlock)
    shut; `CHK("win", 1'h0, directionAccessEnable)
    wr(4'h3, 8'h00); `CHK("out3", 8'h00, padOut[31:24])
    $display("bidirectional test done");
    extAccess = 1; extAddrPhase = 1; extWide16 = 1; extAddr = 16'hBEEF; tick(1);
    `CHK("addr", 16'hBEEF, {padOut[23:16], padOut[7:0]})
    extAddrPhase = 0; extWriteCycle = 1; extWrData = 8'hC3; tick(1);
    `CHK("wdat", 8'hC3, padOut[7:0])
    extWriteCycle = 0; extWide16 = 0; extEn = 64'hFF; extVal = 64'h96; tick(4);
    `CHK("rdat", 8'h96, extRdData)
    `CHK("p2", 8'hFF, padOut[23:16])
    $display("external bus test done");
    print_verdict;
  end
  // Watchdog against a hung sequence
  initial begin #5000; err_total++; print_verdict; end
endmodule : io_port_structure_control_test
